// File: design/cdpf_formatter.sv
`timescale 1ns/1ps
// Contract
// - address record only for fewer than 3 bit errors and enabled address match
// - address record top byte is fixed identifier 0x01
// - byte 2 bit 7 marks priority address
// - byte 2 bits 6:5 carry address phase, A=0 to D=3
// - byte 2 bit 4 marks long address
// - byte 1 holds index, 0x00-0x0F programmable, 0x80-0x8F temporary
// - long address gives one record, indexed by its second word
// - byte 0 bit 7 marks tone-only; no vector record follows it
// - byte 0 bits 6:0 give vector word number 2 to 87
// - every non tone-only address record is followed by a vector record
// - vector record identifier is the vector word number, 0x02 to 0x57
// - more than two vector bit errors sets error flag, suppresses messages
// - failed check character or invalid vector also sets error flag
// - numeric vector layout: word number, error, phase, vector type
// - byte 1 bits 5:2 carry four first checksum bits
// - three-bit message length, 000 is one word, long counts second vector
// - long address first message word follows the vector word
// - byte 0 bits 6:0 give message start 3 to 87
// - vector type 011 standard, 100 special, 111 numbered numeric
// - vector phase field encodes A=0 to D=3
module cdpf_formatter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic addr_valid,
  input wire logic [2:0] addr_errs,
  input wire logic addr_hit,
  input wire logic addr_temp,
  input wire logic [3:0] addr_slot,
  input wire logic priority_flag,
  input wire logic long_addr_flag,
  input wire logic addr_second_word,
  input wire logic tone_only_flag,
  input wire logic [1:0] addr_phase,
  input wire logic [6:0] vector_word_number,
  input wire logic vec_valid,
  input wire logic [6:0] vec_word_number,
  input wire logic [1:0] vec_phase,
  input wire logic [2:0] vec_errs,
  input wire logic vec_check_fail,
  input wire logic vec_invalid,
  input wire logic [2:0] vec_type,
  input wire logic [3:0] vec_checksum,
  input wire logic [2:0] vec_length,
  input wire logic [6:0] vec_msg_start,
  input wire logic vec_long,
  output logic rec_ready,
  output logic vec_pending,
  output logic msg_enable,
  output logic msg_suppress,
  output logic [6:0] msg_first_word,
  output logic link_frame,
  output logic link_data
);

  function automatic logic wn_ok(input logic [6:0] wn, input logic [6:0] lo);
    wn_ok = (wn >= lo) && (wn <= cdpf_pkg::WN_MAX);
  endfunction

  function automatic logic numeric_type(input logic [2:0] vt);
    numeric_type = (vt == cdpf_pkg::VT_STD_NUMERIC) ||
                   (vt == cdpf_pkg::VT_SPECIAL_NUMERIC) ||
                   (vt == cdpf_pkg::VT_NUMBERED_NUMERIC);
  endfunction

  // system clock side
  logic hold_full_q;
  logic [31:0] hold_q;
  logic req_tgl_q;
  logic [2:0] ack_s_q;
  logic ack_seen_q;
  logic vec_pending_q;
  logic msg_enable_q;
  logic msg_suppress_q;
  logic [6:0] msg_first_word_q;
  logic addr_take;
  logic vec_take;
  logic vec_err;
  logic ack_done;
  logic [7:0] addr_index;
  logic [31:0] addr_rec;
  logic [31:0] vec_rec;
  logic [31:0] rec_d;

  // crossing and field signals
  logic ack_tgl_q;
  logic addr_err_ok;
  logic addr_match;
  logic addr_word_ok;
  logic addr_wn_ok;
  logic [6:0] addr_wn_field;
  logic [7:0] addr_byte3;
  logic [7:0] addr_byte2;
  logic [7:0] addr_byte1;
  logic [7:0] addr_byte0;
  logic vec_type_ok;
  logic vec_wn_ok;
  logic vec_start_ok;
  logic [7:0] vec_byte3;
  logic [7:0] vec_byte2;
  logic [7:0] vec_byte1;
  logic [7:0] vec_byte0;
  logic [6:0] msg_first_word_d;

  assign rec_ready = !hold_full_q;
  assign vec_pending = vec_pending_q;
  assign msg_enable = msg_enable_q;
  assign msg_suppress = msg_suppress_q;
  assign msg_first_word = msg_first_word_q;

  always_comb begin
    addr_err_ok = (addr_errs < cdpf_pkg::ADDR_ERR_LIMIT);
    addr_match = addr_valid && addr_hit;
    addr_word_ok = !long_addr_flag || addr_second_word;
    addr_wn_ok = tone_only_flag || wn_ok(vector_word_number, cdpf_pkg::WN_MIN);
    addr_take = rec_ready && addr_match && addr_err_ok && addr_word_ok && addr_wn_ok;
    vec_type_ok = numeric_type(vec_type);
    vec_wn_ok = wn_ok(vec_word_number, cdpf_pkg::WN_MIN);
    vec_start_ok = wn_ok(vec_msg_start, cdpf_pkg::MSG_START_MIN);
    vec_take = rec_ready && !addr_take && vec_valid && vec_type_ok && vec_wn_ok && vec_start_ok;
    vec_err = (vec_errs > cdpf_pkg::VEC_ERR_LIMIT)
              || vec_check_fail || vec_invalid;
    addr_index = (addr_temp ? cdpf_pkg::TEMP_INDEX_BASE : cdpf_pkg::PROG_INDEX_BASE)
                 | {4'h0, addr_slot};
    addr_wn_field = tone_only_flag ? 7'h00 : vector_word_number;
    addr_byte3 = cdpf_pkg::ADDR_REC_ID;
    addr_byte2 = {priority_flag,
                  addr_phase,
                  long_addr_flag,
                  4'h0};
    addr_byte1 = addr_index;
    addr_byte0 = {tone_only_flag, addr_wn_field};
    addr_rec = {addr_byte3, addr_byte2, addr_byte1, addr_byte0};
    vec_byte3 = {1'b0, vec_word_number};
    vec_byte2 = {vec_err, vec_phase, 2'b00, vec_type};
    vec_byte1 = {2'b00, vec_checksum, vec_length[2:1]};
    vec_byte0 = {vec_length[0], vec_msg_start};
    vec_rec = {vec_byte3, vec_byte2, vec_byte1, vec_byte0};
  end

  // address wins over vector
  always_comb begin
    if (addr_take) begin
      rec_d = addr_rec;
    end else begin
      rec_d = vec_rec;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_q <= cdpf_pkg::REC_RESET;
    end else if (addr_take || vec_take) begin
      hold_q <= rec_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_full_q <= 1'b0;
    end else if (addr_take || vec_take) begin
      hold_full_q <= 1'b1;
    end else if (ack_done) begin
      hold_full_q <= 1'b0;
    end
  end

  // request toggle, one flip per record
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_tgl_q <= 1'b0;
    end else if (addr_take || vec_take) begin
      req_tgl_q <= !req_tgl_q;
    end
  end

  // ack toggle from link side, three stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_s_q <= 3'h0;
    end else begin
      ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
    end
  end

  // last agreed ack level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_seen_q <= 1'b0;
    end else if (ack_s_q[1] == ack_s_q[2]) begin
      ack_seen_q <= ack_s_q[2];
    end
  end

  assign ack_done = hold_full_q && (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] == req_tgl_q)
                    && (ack_seen_q != ack_s_q[2]);

  // outstanding vector after a non tone-only address; set wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vec_pending_q <= 1'b0;
    end else if (addr_take && !tone_only_flag) begin
      vec_pending_q <= 1'b1;
    end else if (vec_take) begin
      vec_pending_q <= 1'b0;
    end
  end

  // message word steering
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msg_enable_q <= 1'b0;
    end else begin
      msg_enable_q <= vec_take && !vec_err;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msg_suppress_q <= 1'b0;
    end else begin
      msg_suppress_q <= vec_take && vec_err;
    end
  end

  always_comb begin
    if (vec_long) begin
      msg_first_word_d = vec_word_number + 7'h01;
    end else begin
      msg_first_word_d = vec_msg_start;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msg_first_word_q <= 7'h00;
    end else if (vec_take) begin
      msg_first_word_q <= msg_first_word_d;
    end
  end

  // link clock side
  logic [2:0] rst_s_q;
  logic link_rst;
  logic [2:0] req_s_q;
  logic req_seen_q;
  logic [31:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic link_frame_q;
  logic link_data_q;
  cdpf_pkg::cdpf_link_e link_st_q;
  cdpf_pkg::cdpf_link_e link_st_d;
  logic req_new;
  logic link_load;
  logic link_shift;
  logic link_last;

  assign link_rst = rst_s_q[2];
  assign req_new = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != req_seen_q);
  assign link_frame = link_frame_q;
  assign link_data = link_data_q;

  always_ff @(posedge link_clk) begin
    rst_s_q <= {rst_s_q[1:0], sys_rst};
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_s_q <= 3'h0;
    end else begin
      req_s_q <= {req_s_q[1:0], req_tgl_q};
    end
  end

  // link state decode
  always_comb begin
    link_load = 1'b0;
    link_shift = 1'b0;
    link_last = (bit_cnt_q == cdpf_pkg::BIT_CNT_LAST - 5'h01);
    link_st_d = link_st_q;
    case (link_st_q)
      cdpf_pkg::CDPF_IDLE: begin
        if (req_new) begin
          link_load = 1'b1;
          link_st_d = cdpf_pkg::CDPF_SHIFT;
        end
      end
      cdpf_pkg::CDPF_SHIFT: begin
        link_shift = 1'b1;
        if (link_last) begin
          link_st_d = cdpf_pkg::CDPF_GAP;
        end
      end
      cdpf_pkg::CDPF_GAP: begin
        link_st_d = cdpf_pkg::CDPF_IDLE;
      end
      default: begin
        link_st_d = cdpf_pkg::CDPF_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_st_q <= cdpf_pkg::CDPF_IDLE;
    end else begin
      link_st_q <= link_st_d;
    end
  end

  // accepted request level
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_seen_q <= 1'b0;
    end else if (link_load) begin
      req_seen_q <= req_s_q[2];
    end
  end

  // ack once the record is latched
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ack_tgl_q <= 1'b0;
    end else if (link_load) begin
      ack_tgl_q <= req_s_q[2];
    end
  end

  // serial shifter, msb first
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      shift_q <= cdpf_pkg::REC_RESET;
    end else if (link_load) begin
      shift_q <= {hold_q[30:0], 1'b0};
    end else if (link_shift) begin
      shift_q <= {shift_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      bit_cnt_q <= 5'h00;
    end else if (link_load) begin
      bit_cnt_q <= 5'h00;
    end else if (link_shift) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_frame_q <= 1'b0;
    end else if (link_load) begin
      link_frame_q <= 1'b1;
    end else if (!link_shift) begin
      link_frame_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_data_q <= 1'b0;
    end else if (link_load) begin
      link_data_q <= hold_q[31];
    end else if (link_shift) begin
      link_data_q <= shift_q[31];
    end else begin
      link_data_q <= 1'b0;
    end
  end

endmodule // cdpf_formatter

// File: design/cdpf_pkg.sv
package cdpf_pkg;
  localparam int REC_BITS = 32;
  localparam int SYNC_LEN = 3;
  localparam logic [7:0] ADDR_REC_ID = 8'h01;
  localparam logic [2:0] ADDR_ERR_LIMIT = 3'h3;
  localparam logic [2:0] VEC_ERR_LIMIT = 3'h2;
  localparam logic [6:0] WN_MIN = 7'h02;
  localparam logic [6:0] WN_MAX = 7'h57;
  localparam logic [6:0] MSG_START_MIN = 7'h03;
  localparam logic [7:0] TEMP_INDEX_BASE = 8'h80;
  localparam logic [7:0] PROG_INDEX_BASE = 8'h00;
  localparam logic [2:0] VT_STD_NUMERIC = 3'h3;
  localparam logic [2:0] VT_SPECIAL_NUMERIC = 3'h4;
  localparam logic [2:0] VT_NUMBERED_NUMERIC = 3'h7;
  localparam logic [4:0] BIT_CNT_LAST = 5'h1f;
  localparam logic [31:0] REC_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    CDPF_IDLE = 2'b00,
    CDPF_SHIFT = 2'b01,
    CDPF_GAP = 2'b11
  } cdpf_link_e;
endpackage

// File: test/cdpf_formatter_sva.sv
`timescale 1ns/1ps
module cdpf_formatter_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic addr_valid,
  input wire logic [2:0] addr_errs,
  input wire logic addr_hit,
  input wire logic long_addr_flag,
  input wire logic tone_only_flag,
  input wire logic [6:0] vector_word_number,
  input wire logic vec_valid,
  input wire logic [6:0] vec_word_number,
  input wire logic [2:0] vec_errs,
  input wire logic vec_check_fail,
  input wire logic vec_invalid,
  input wire logic [2:0] vec_type,
  input wire logic [6:0] vec_msg_start,
  input wire logic vec_long,
  input wire logic rec_ready,
  input wire logic vec_pending,
  input wire logic msg_enable,
  input wire logic msg_suppress,
  input wire logic [6:0] msg_first_word
);
  logic at, vt, ve;
  assign at = rec_ready && addr_valid && addr_errs < 3'h3 && addr_hit && !long_addr_flag
    && (tone_only_flag || vector_word_number inside {[7'h02:7'h57]});
  assign vt = rec_ready && vec_valid && !addr_valid && vec_type inside {3'h3, 3'h4, 3'h7}
    && vec_word_number inside {[7'h02:7'h57]} && vec_msg_start inside {[7'h03:7'h57]};
  assign ve = vec_errs > 3'h2 || vec_check_fail || vec_invalid;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  take_busy_a: assert property (at |=> !rec_ready) else $error("address not taken");
  err_drop_a: assert property (rec_ready && addr_valid && addr_errs > 3'h2 && !vec_valid
    |=> rec_ready) else $error("bad address taken");
  pend_set_a: assert property (at && !tone_only_flag |=> vec_pending) else $error("no pend");
  tone_pend_a: assert property (at && tone_only_flag && !vec_pending |=> !vec_pending)
    else $error("tone pend");
  vec_err_a: assert property (vt && ve |=> msg_suppress && !msg_enable)
    else $error("error vector let messages");
  vec_chk_a: assert property (vt && (vec_check_fail || vec_invalid) |=> msg_suppress)
    else $error("check fail not flagged");
  vec_ok_a: assert property (vt && !ve |=> msg_enable ##1 !msg_enable)
    else $error("enable pulse wrong");
  first_long_a: assert property (vt && !ve && vec_long
    |=> msg_first_word == $past(vec_word_number) + 7'h01) else $error("long first");
  pend_clr_a: assert property (vt |=> !vec_pending) else $error("pend kept");
  cover property (at && tone_only_flag);
  cover property (vt && ve);
  cover property (vt && vec_long);
endmodule // cdpf_formatter_sva

// File: test/cdpf_host_rx.sv
`timescale 1ns/1ps
module cdpf_host_rx (
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_data,
  output logic [31:0] rec = 32'h0,
  output logic [7:0] got = 8'h00
);
  logic [31:0] sh = 32'h0;
  logic [5:0] nb = 6'h00;
  logic fq = 1'b0;
  // shifts msb first while framed, spoils a short or long record
  always @(posedge link_clk) begin
    fq <= link_frame;
    if (link_frame) begin
      sh <= {sh[30:0], link_data};
      nb <= nb + 6'h01;
    end else if (fq) begin
      rec <= (nb == 6'h20) ? sh : ~sh;
      got <= got + 8'h01;
      nb <= 6'h00;
    end
  end
endmodule // cdpf_host_rx

// File: test/test_call_data_packet_formatter.sv
`timescale 1ns/1ps
`define CHK(a, b) chk(32'(a), 32'(b))
module test_call_data_packet_formatter;
  logic clk, sys_rst, link_clk, addr_valid, addr_hit, addr_temp, priority_flag;
  logic long_addr_flag, addr_second_word, tone_only_flag, vec_valid, vec_check_fail;
  logic vec_invalid, vec_long, rec_ready, vec_pending, msg_enable, msg_suppress;
  logic link_frame, link_data;
  logic [1:0] addr_phase, vec_phase;
  logic [2:0] addr_errs, vec_errs, vec_type, vec_length;
  logic [3:0] addr_slot, vec_checksum;
  logic [6:0] vector_word_number, vec_word_number, vec_msg_start, msg_first_word;
  logic [31:0] rec;
  logic [7:0] got;
  int error_cnt = 0;
  int cmp_count = 0;
  cdpf_formatter cdpf_formatter_inst(.*);
  cdpf_host_rx cdpf_host_rx_inst(.*);
  initial begin clk = 0; forever #2 clk = ~clk; end
  initial begin link_clk = 0; #0.5; forever #3 link_clk = ~link_clk; end
  initial begin #100000; error_cnt++; results; end
  task chk(input logic [31:0] a, b);
    cmp_count++;
    if (a !== b) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, a, b);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task idle;
    for (int k = 0; k < 200 && rec_ready !== 1'b1; k++) @(negedge clk);
  endtask
  task addr(input logic [2:0] e, input logic h, tm, pf, la, sw, to, input logic [1:0] ph,
    input logic [3:0] sl, input logic [6:0] wn);
    idle;
    {addr_errs, addr_hit, addr_temp, priority_flag, long_addr_flag, addr_second_word,
      tone_only_flag, addr_phase, addr_slot, vector_word_number} = {e, h, tm, pf, la, sw, to,
      ph, sl, wn};
    addr_valid = 1;
    @(negedge clk) addr_valid = 0;
  endtask
  task vec(input logic [2:0] e, input logic cf, iv, lg, input logic [1:0] ph,
    input logic [2:0] ty, n, input logic [3:0] k, input logic [6:0] wn, b);
    idle;
    {vec_errs, vec_check_fail, vec_invalid, vec_long, vec_phase, vec_type, vec_length,
      vec_checksum, vec_word_number, vec_msg_start} = {e, cf, iv, lg, ph, ty, n, k, wn, b};
    vec_valid = 1;
    @(negedge clk) vec_valid = 0;
  endtask
  task rx(input logic [31:0] exp, msk, input logic [7:0] d);
    logic [7:0] n;
    n = got;
    for (int k = 0; k < 150 && got == n; k++) @(negedge clk);
    `CHK(got - n, d);
    if (d != 0) `CHK(rec & msk, exp & msk);
  endtask
  initial begin
    {addr_valid, addr_errs, addr_hit, addr_temp, addr_slot, priority_flag, long_addr_flag,
      addr_second_word, tone_only_flag, addr_phase, vector_word_number} = '0;
    {vec_valid, vec_word_number, vec_phase, vec_errs, vec_check_fail, vec_invalid, vec_type,
      vec_checksum, vec_length, vec_msg_start, vec_long} = '0;
    sys_rst = 1;
    repeat (5) @(negedge clk);
    sys_rst = 0;
    for (int i = 0; i < 4; i++) begin
      logic [6:0] w;
      w = (i == 3) ? 7'h57 : 7'(2 + 28 * i);
      addr(3'(i % 3), 1, i[1], i[0], 0, 0, 0, 2'(i), 4'(5 * i), w);
      `CHK(vec_pending, 1);
      rx({8'h01, i[0], 2'(i), 5'h00, i[1], 3'h0, 4'(5 * i), 1'b0, w}, 32'hfff0ffff, 1);
    end
    done("address");
    addr(0, 1, 0, 0, 1, 0, 0, 2'h1, 4'h3, 7'h10);
    rx(0, 0, 0);
    addr(0, 1, 0, 0, 1, 1, 0, 2'h1, 4'h4, 7'h10);
    rx({8'h01, 1'b0, 2'h1, 5'h10, 8'h04, 8'h10}, 32'hfff0ffff, 1);
    addr(3, 1, 0, 0, 0, 0, 0, 0, 0, 7'h20);
    rx(0, 0, 0);
    addr(0, 0, 0, 0, 0, 0, 0, 0, 0, 7'h20);
    rx(0, 0, 0);
    done("long and refused");
    for (int j = 0; j < 5; j++) begin
      logic [2:0] t;
      logic e;
      t = (j % 3 == 0) ? 3'h3 : (j % 3 == 1) ? 3'h4 : 3'h7;
      e = (j > 0 && j < 4);
      vec(j == 1 ? 3'h3 : 3'h2, j == 2, j == 3, j == 4, 2'(j), t, 3'(j), 4'(9 + j),
        7'(20 + j), 7'(40 + j));
      `CHK(vec_pending, 0);
      if (j % 4 == 0) `CHK(msg_first_word, j ? 7'h19 : 7'h28);
      rx({1'b0, 7'(20 + j), e, 2'(j), 2'b00, t, 2'b00, 4'(9 + j), 3'(j), 7'(40 + j)},
        32'hffe73fff, 1);
    end
    done("vector");
    addr(0, 1, 1, 1, 0, 0, 1, 2'h3, 4'hf, 7'h30);
    `CHK(vec_pending, 0);
    rx({8'h01, 1'b1, 2'h3, 5'h00, 8'h8f, 8'h80}, 32'hfff0ff80, 1);
    done("tone only");
    results;
  end
endmodule // test_call_data_packet_formatter
bind cdpf_formatter cdpf_formatter_sva cdpf_formatter_sva_inst(.*);
